// [hdl/fpc_pkg.sv]
// Constants for the flash pin command host controller.
// How it works
// - sector address goes as two bytes: bits 0-7, then bits 8-14, bit 7 zero.
// - column address goes as two bytes: bits 0-7, then bits 8-11, top zero.
// - qualifier low marks command or data, high marks an address byte.
// - host writes the command sequence before any read, program or erase.
// - host saves the sector validity marker before erasing a sector.
// - host writes the saved validity marker back when reprogramming.
package fpc_pkg;
	localparam int unsigned FPC_CLK_MHZ = 125;
	localparam int unsigned FPC_PHASE_NS = 48;
	localparam int unsigned FPC_PHASE_CYC =
		(FPC_PHASE_NS * FPC_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] FPC_CMD_READ = 8'h00;
	localparam logic [7:0] FPC_CMD_PROG = 8'h10;
	localparam logic [7:0] FPC_CMD_ERASE = 8'h20;
	localparam logic [7:0] FPC_CMD_PCONF = 8'h40;
	localparam logic [7:0] FPC_CMD_ECONF = 8'hB0;
	localparam logic [7:0] FPC_CMD_RESET = 8'hFF;
	localparam logic [11:0] FPC_VALID_COL = 12'h800;
	localparam logic [5:0] FPC_VALID_LEN = 6'h3F;
	localparam logic [1:0] FPC_OP_READ = 2'h0;
	localparam logic [1:0] FPC_OP_PROG = 2'h1;
	localparam logic [1:0] FPC_OP_ERASE = 2'h2;
	localparam logic [1:0] FPC_OP_STAT = 2'h3;
endpackage

// [hdl/fpc_strobe_if.sv]
// Interface between the sequencer and the pin timing engine.
`timescale 1ns/1ps
interface fpc_strobe_if;
	logic req;
	logic [1:0] kind;
	logic [7:0] wdata;
	logic qual;
	logic done;
	logic [7:0] rdata;
	modport seq(output req, output kind, output wdata, output qual,
		input done, input rdata);
	modport eng(input req, input kind, input wdata, input qual,
		output done, output rdata);
endinterface

// [hdl/fpc_pin_engine.sv]
// Pin timing engine: one bus cycle of write strobe, clock or read.
`timescale 1ns/1ps
module fpc_pin_engine
	import fpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	fpc_strobe_if.eng sif,
	input wire logic [7:0] bus_in,
	output logic we_n,
	output logic oe_n,
	output logic sclk,
	output logic qual_n,
	output logic [7:0] bus_out,
	output logic bus_oe
);
	// Kind 0 write strobe, 1 clock write, 2 clock read, 3 output-enable read.
	typedef enum logic [2:0] {
		FPC_E_IDLE = 3'b001,
		FPC_E_ACT = 3'b010,
		FPC_E_REL = 3'b100
	} fpc_eng_t;
	fpc_eng_t st_q;
	logic [7:0] cnt_q;
	logic [1:0] kind_q;
	logic [2:0] bsync_q [8];
	logic [7:0] bus_s;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					bsync_q[g] <= 3'h0;
				end else begin
					bsync_q[g] <= {bsync_q[g][1:0], bus_in[g]};
				end
			end
			assign bus_s[g] = bsync_q[g][2];
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= FPC_E_IDLE;
			cnt_q <= 8'h0;
			kind_q <= 2'h0;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			sclk <= 1'b0;
			qual_n <= 1'b0;
			bus_out <= 8'h0;
			bus_oe <= 1'b0;
			sif.done <= 1'b0;
			sif.rdata <= 8'h0;
		end else begin
			sif.done <= 1'b0;
			unique case (st_q)
				FPC_E_IDLE: begin
					if (sif.req) begin
						kind_q <= sif.kind;
						qual_n <= sif.qual;
						bus_out <= sif.wdata;
						bus_oe <= !sif.kind[1];
						we_n <= (sif.kind != 2'h0);
						oe_n <= !sif.kind[1];
						cnt_q <= 8'(FPC_PHASE_CYC);
						st_q <= FPC_E_ACT;
					end
				end
				FPC_E_ACT: begin
					if (cnt_q != 8'h0) begin
						cnt_q <= cnt_q - 8'h1;
					end else begin
						if (kind_q[1]) begin
							sif.rdata <= bus_s;
						end
						we_n <= 1'b1;
						sclk <= (kind_q == 2'h1) || (kind_q == 2'h2);
						oe_n <= 1'b1;
						cnt_q <= 8'(FPC_PHASE_CYC);
						st_q <= FPC_E_REL;
					end
				end
				FPC_E_REL: begin
					if (cnt_q != 8'h0) begin
						cnt_q <= cnt_q - 8'h1;
					end else begin
						sclk <= 1'b0;
						bus_oe <= 1'b0;
						sif.done <= 1'b1;
						st_q <= FPC_E_IDLE;
					end
				end
				default: st_q <= FPC_E_IDLE;
			endcase
		end
	end
endmodule

// [hdl/fpc_host.sv]
// Host controller that runs read, program, erase and status on the flash.
`timescale 1ns/1ps
module fpc_host
	import fpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic op_valid,
	input wire logic [1:0] op_kind,
	input wire logic [14:0] op_sector,
	input wire logic [11:0] op_column,
	input wire logic [7:0] op_wdata,
	output logic op_ready,
	output logic wr_req,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic op_done,
	output logic [7:0] mark_data,
	output logic mark_valid,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic sclk,
	output logic cmd_data_qualifier_n,
	output logic reset_n,
	output logic [7:0] bidir_bus_out,
	output logic bidir_bus_oe,
	input wire logic [7:0] bidir_bus_in,
	input wire logic rdy_busy_in,
	input wire logic [11:0] op_count
);
	typedef enum logic [6:0] {
		FPC_S_IDLE = 7'b0000001,
		FPC_S_CMD = 7'b0000010,
		FPC_S_SAVE = 7'b0000100,
		FPC_S_DATA = 7'b0001000,
		FPC_S_CONF = 7'b0010000,
		FPC_S_BUSY = 7'b0100000,
		FPC_S_END = 7'b1000000
	} fpc_st_t;
	fpc_st_t st_q;
	fpc_strobe_if sif();
	logic busy_pend_q;
	logic [2:0] step_q;
	logic [1:0] kind_q;
	logic [14:0] sec_q;
	logic [11:0] col_q;
	logic [11:0] left_q;
	logic [5:0] midx_q;
	logic [7:0] mark_q [64];
	logic [2:0] rb_q;
	logic rb_ok;

	fpc_pin_engine u_eng (
		.ref_clk(ref_clk),
		.srst(srst),
		.sif(sif.eng),
		.bus_in(bidir_bus_in),
		.we_n(we_n),
		.oe_n(oe_n),
		.sclk(sclk),
		.qual_n(cmd_data_qualifier_n),
		.bus_out(bidir_bus_out),
		.bus_oe(bidir_bus_oe)
	);

	// Ready is taken once the second and third sync stages agree high.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rb_q <= 3'h0;
			rb_ok <= 1'b0;
		end else begin
			rb_q <= {rb_q[1:0], rdy_busy_in};
			if (rb_q[2] == rb_q[1]) begin
				rb_ok <= rb_q[1];
			end
		end
	end

	// Reset pin released one edge after srst, so no operation runs in reset.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reset_n <= 1'b0;
		end else begin
			reset_n <= 1'b1;
		end
	end

	// Address byte of step n: sector low, sector high, column low, high.
	function automatic logic [7:0] addr_byte(input logic [2:0] n,
		input logic [14:0] s, input logic [11:0] c);
		unique case (n)
			3'h1: addr_byte = s[7:0];
			3'h2: addr_byte = {1'b0, s[14:8]};
			3'h3: addr_byte = c[7:0];
			default: addr_byte = {4'h0, c[11:8]};
		endcase
	endfunction

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= FPC_S_IDLE;
			op_ready <= 1'b0;
			wr_req <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h0;
			op_done <= 1'b0;
			ce_n <= 1'b1;
			sif.req <= 1'b0;
			sif.kind <= 2'h0;
			sif.wdata <= 8'h0;
			sif.qual <= 1'b0;
			step_q <= 3'h0;
			kind_q <= 2'h0;
			sec_q <= 15'h0;
			col_q <= 12'h0;
			left_q <= 12'h0;
			midx_q <= 6'h0;
			busy_pend_q <= 1'b0;
		end else begin
			sif.req <= 1'b0;
			rd_valid <= 1'b0;
			wr_req <= 1'b0;
			op_done <= 1'b0;
			op_ready <= (st_q == FPC_S_IDLE) && rb_ok && reset_n;
			unique case (st_q)
				FPC_S_IDLE: begin
					if (op_valid && op_ready) begin
						op_ready <= 1'b0;
						kind_q <= op_kind;
						sec_q <= op_sector;
						col_q <= op_column;
						left_q <= op_count;
						ce_n <= 1'b0;
						step_q <= 3'h0;
						midx_q <= 6'h0;
						if (op_kind == FPC_OP_STAT) begin
							sif.kind <= 2'h3;
							sif.req <= 1'b1;
							st_q <= FPC_S_DATA;
						end else if (op_kind == FPC_OP_ERASE) begin
							// Save the validity marker first with a read.
							kind_q <= FPC_OP_READ;
							col_q <= FPC_VALID_COL;
							left_q <= {6'h0, FPC_VALID_LEN};
							busy_pend_q <= 1'b1;
							sif.req <= 1'b1;
							sif.kind <= 2'h0;
							sif.qual <= 1'b0;
							sif.wdata <= FPC_CMD_READ;
							st_q <= FPC_S_CMD;
						end else begin
							busy_pend_q <= 1'b0;
							sif.req <= 1'b1;
							sif.kind <= 2'h0;
							sif.qual <= 1'b0;
							sif.wdata <= (op_kind == FPC_OP_PROG) ?
								FPC_CMD_PROG : FPC_CMD_READ;
							st_q <= FPC_S_CMD;
						end
					end
				end
				FPC_S_CMD: begin
					if (sif.done) begin
						if (step_q == 3'h4 ||
							(kind_q == FPC_OP_ERASE && step_q == 3'h2)) begin
							st_q <= (kind_q == FPC_OP_ERASE) ?
								FPC_S_CONF : FPC_S_DATA;
							sif.req <= 1'b1;
							if (kind_q == FPC_OP_ERASE) begin
								sif.kind <= 2'h0;
								sif.qual <= 1'b0;
								sif.wdata <= FPC_CMD_ECONF;
							end else if (kind_q == FPC_OP_PROG) begin
								sif.kind <= 2'h1;
								sif.qual <= 1'b0;
								sif.wdata <= (col_q >= FPC_VALID_COL &&
									col_q <= FPC_VALID_COL + 12'(FPC_VALID_LEN))
									? mark_q[col_q[5:0]] : op_wdata;
								wr_req <= 1'b1;
							end else begin
								sif.kind <= 2'h2;
								sif.qual <= 1'b0;
							end
						end else begin
							step_q <= step_q + 3'h1;
							sif.req <= 1'b1;
							sif.kind <= 2'h0;
							sif.qual <= 1'b1;
							sif.wdata <= addr_byte(step_q + 3'h1, sec_q, col_q);
						end
					end
				end
				FPC_S_DATA: begin
					if (sif.done) begin
						if (kind_q == FPC_OP_READ || kind_q == FPC_OP_STAT) begin
							rd_valid <= 1'b1;
							rd_data <= sif.rdata;
						end
						if (busy_pend_q) begin
							midx_q <= midx_q + 6'h1;
						end
						col_q <= col_q + 12'h1;
						if (left_q == 12'h0 || kind_q == FPC_OP_STAT) begin
							if (kind_q == FPC_OP_PROG) begin
								sif.req <= 1'b1;
								sif.kind <= 2'h0;
								sif.qual <= 1'b0;
								sif.wdata <= FPC_CMD_PCONF;
								st_q <= FPC_S_CONF;
							end else begin
								ce_n <= 1'b1;
								st_q <= FPC_S_END;
							end
						end else begin
							left_q <= left_q - 12'h1;
							sif.req <= 1'b1;
							if (kind_q == FPC_OP_PROG) begin
								sif.wdata <= (col_q + 12'h1 >= FPC_VALID_COL &&
									col_q + 12'h1 <= FPC_VALID_COL +
									12'(FPC_VALID_LEN)) ?
									mark_q[6'(col_q + 12'h1)] : op_wdata;
								wr_req <= 1'b1;
							end
						end
					end
				end
				FPC_S_CONF: begin
					if (sif.done) begin
						// Chip select stays low until ready returns.
						st_q <= FPC_S_BUSY;
					end
				end
				FPC_S_BUSY: begin
					if (rb_q[2] && rb_q[1] && rb_ok) begin
						ce_n <= 1'b1;
						st_q <= FPC_S_END;
					end
				end
				FPC_S_END: begin
					if (busy_pend_q) begin
						// Marker saved; now run the erase itself.
						busy_pend_q <= 1'b0;
						kind_q <= FPC_OP_ERASE;
						ce_n <= 1'b0;
						step_q <= 3'h0;
						sif.req <= 1'b1;
						sif.kind <= 2'h0;
						sif.qual <= 1'b0;
						sif.wdata <= FPC_CMD_ERASE;
						st_q <= FPC_S_CMD;
					end else begin
						op_done <= 1'b1;
						st_q <= FPC_S_IDLE;
					end
				end
				default: st_q <= FPC_S_IDLE;
			endcase
		end
	end

	// Marker store, filled by the validity read ahead of an erase.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mark_valid <= 1'b0;
			mark_data <= 8'h0;
		end else begin
			if (st_q == FPC_S_DATA && sif.done && busy_pend_q) begin
				mark_q[midx_q] <= sif.rdata;
				mark_valid <= 1'b1;
				mark_data <= sif.rdata;
			end
		end
	end
endmodule

// [tb/fpc_host_asserts.sv]
// Pin-level checks on the flash host controller.
`timescale 1ns/1ps
module fpc_host_asserts (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic op_ready,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic sclk,
	input wire logic cmd_data_qualifier_n,
	input wire logic reset_n,
	input wire logic [7:0] bidir_bus_out,
	input wire logic bidir_bus_oe,
	input wire logic rdy_busy_in
);
	logic [2:0] acnt_q;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// Counts address bytes latched since the last command byte.
	always_ff @(posedge ref_clk) begin
		if (srst || ($rose(we_n) && !cmd_data_qualifier_n)) begin
			acnt_q <= 3'h0;
		end else if ($rose(we_n)) begin
			acnt_q <= acnt_q + 3'h1;
		end
	end
	bus_clash_a: assert property (bidir_bus_oe |-> oe_n)
		else $error("host drives bus with device output on");
	strobe_sel_a: assert property ($rose(we_n) |-> !ce_n && !sclk)
		else $error("write strobe outside command write");
	latch_hold_a: assert property ($rose(we_n) |-> bidir_bus_oe &&
		$stable(bidir_bus_out) && $stable(cmd_data_qualifier_n))
		else $error("bus or qualifier moved at strobe");
	reset_quiet_a: assert property (!reset_n |-> we_n && !sclk)
		else $error("strobe while device in reset");
	sclk_sel_a: assert property ($rose(sclk) |-> !ce_n && we_n)
		else $error("data clock outside selected cycle");
	busy_wait_a: assert property (!rdy_busy_in [*6] |-> !op_ready)
		else $error("ready offered while device busy");
	sector_hi_a: assert property ($rose(we_n) && cmd_data_qualifier_n &&
		acnt_q == 3'h1 |-> !bidir_bus_out[7])
		else $error("sector high byte bit 7 set");
	column_hi_a: assert property ($rose(we_n) && cmd_data_qualifier_n &&
		acnt_q == 3'h3 |-> bidir_bus_out[7:4] == 4'h0)
		else $error("column high byte upper bits set");
endmodule
bind fpc_host fpc_host_asserts fpc_host_asserts_inst (.ref_clk, .srst,
	.op_ready, .ce_n, .oe_n, .we_n, .sclk, .cmd_data_qualifier_n, .reset_n,
	.bidir_bus_out, .bidir_bus_oe, .rdy_busy_in);

// [tb/fpc_flash_model.sv]
// Behavioural model of one flash die seen at its pins.
`timescale 1ns/1ps
module fpc_flash_model #(
	parameter int BUSY_NS = 3000
) (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic sclk,
	input wire logic qual_n,
	input wire logic reset_n,
	input wire logic [7:0] bus_in,
	output logic [7:0] bus_out,
	output logic rb_low
);
	logic [7:0] mem [0:4095];
	logic [7:0] cmd_q = 8'hFF;
	logic [7:0] col_q;
	logic [7:0] dout_q = 8'h00;
	logic [7:0] val;
	logic [2:0] acnt_q = 3'h0;
	logic [11:0] ptr_q;
	logic busy_q = 1'b0;
	logic rd_q = 1'b0;
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5A;
	always @(posedge we_n) begin
		if (!ce_n && reset_n && !qual_n) begin
			if ((bus_in == 8'h40 && cmd_q == 8'h10) ||
				(bus_in == 8'hB0 && cmd_q == 8'h20)) begin
				busy_q = 1'b1;
				for (int i = 0; i < 4096 && cmd_q == 8'h20; i++) begin
					mem[i] = 8'hFF;
				end
			end
			acnt_q = 3'h0;
			rd_q = bus_in == 8'h00;
			cmd_q = bus_in;
		end else if (!ce_n && reset_n) begin
			col_q = acnt_q == 3'h2 ? bus_in : col_q;
			ptr_q = {bus_in[3:0], col_q};
			// The first byte is ready once the address is complete.
			dout_q = mem[ptr_q];
			acnt_q = acnt_q + 3'h1;
		end
	end
	always @(posedge busy_q) #(BUSY_NS) busy_q = 1'b0;
	always @(posedge ce_n) rd_q = rd_q && busy_q;
	always @(posedge sclk) begin
		if (!ce_n && reset_n) begin
			mem[ptr_q] = cmd_q == 8'h10 ? bus_in : mem[ptr_q];
			ptr_q = ptr_q + 12'h001;
			dout_q = mem[ptr_q];
		end
	end
	assign rb_low = busy_q;
	assign val = rd_q ? dout_q : {~busy_q, 7'h00};
	// A released bus shows the inverse so a stale byte cannot pass.
	assign bus_out = !ce_n && !oe_n && reset_n ? val : ~val;
endmodule

// [tb/testbench.sv]
// Self-checking bench: flash host controller against a die model.
`timescale 1ns/1ps
module testbench;
	import fpc_pkg::*;
	logic ref_clk = 1'b0, srst = 1'b1, op_valid = 1'b0;
	logic [1:0] op_kind = 2'h0;
	logic [14:0] op_sector = 15'h0000;
	logic [11:0] op_column = 12'h000, op_count = 12'h000;
	logic [7:0] op_wdata = 8'h00;
	logic op_ready, wr_req, rd_valid, op_done, mark_valid, ce_n, oe_n;
	logic we_n, sclk, cmd_data_qualifier_n, reset_n, bidir_bus_oe;
	logic rb_low, busy_seen;
	logic [7:0] rd_data, mark_data, bidir_bus_out, dev_bus;
	logic [7:0] rx [$];
	int err_total = 0;
	int checked = 0;
	wire logic [7:0] bidir_bus_in = bidir_bus_oe ? bidir_bus_out : dev_bus;
	// The ready line is the inverse of the model's busy output.
	wire logic rdy_busy_in = !rb_low;
	always #4 ref_clk = ~ref_clk;
	fpc_host fpc_host_inst (.ref_clk, .srst, .op_valid, .op_kind, .op_sector,
		.op_column, .op_wdata, .op_ready, .wr_req, .rd_valid, .rd_data,
		.op_done, .mark_data, .mark_valid, .ce_n, .oe_n, .we_n, .sclk,
		.cmd_data_qualifier_n, .reset_n, .bidir_bus_out, .bidir_bus_oe,
		.bidir_bus_in, .rdy_busy_in, .op_count);
	fpc_flash_model fpc_flash_model_inst (.ce_n, .oe_n, .we_n, .sclk,
		.qual_n(cmd_data_qualifier_n), .reset_n, .bus_in(bidir_bus_in),
		.bus_out(dev_bus), .rb_low);
	task automatic check(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic run_op(input logic [1:0] k, input logic [14:0] s,
		input logic [11:0] c, input logic [11:0] n);
		int t;
		rx.delete();
		busy_seen = 1'b0;
		for (t = 0; op_ready !== 1'b1 && t < 20000; t++) @(negedge ref_clk);
		@(posedge ref_clk);
		op_kind <= k;
		op_sector <= s;
		op_column <= c;
		op_count <= n;
		op_valid <= 1'b1;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		for (; op_done !== 1'b1 && t < 20000; t++) begin
			@(negedge ref_clk);
			if (rd_valid === 1'b1) begin
				rx.push_back(rd_data);
			end
			busy_seen |= rdy_busy_in === 1'b0;
			if (wr_req === 1'b1) begin
				@(posedge ref_clk);
				op_wdata <= op_wdata + 8'h11;
			end
		end
		if (t >= 20000) begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic t_status();
		run_op(FPC_OP_STAT, 15'h0000, 12'h000, 12'h000);
		check("status byte", rx[0], 8'h80);
		$display("status test done");
	endtask
	task automatic t_read();
		run_op(FPC_OP_READ, 15'h7FFF, 12'hFF0, 12'h003);
		check("read count", 8'(rx.size()), 8'h04);
		foreach (rx[i]) begin
			check("read byte", rx[i], 8'hAA ^ 8'(i));
		end
		$display("read test done");
	endtask
	task automatic t_erase();
		run_op(FPC_OP_ERASE, 15'h0002, 12'h000, 12'h000);
		check("busy seen", {7'h00, busy_seen}, 8'h01);
		check("ready after", {7'h00, rdy_busy_in}, 8'h01);
		check("marker valid", {7'h00, mark_valid}, 8'h01);
		check("marker byte", mark_data, 8'h65);
		$display("erase test done");
	endtask
	task automatic t_prog();
		@(posedge ref_clk);
		op_wdata <= 8'hA5;
		run_op(FPC_OP_PROG, 15'h4002, 12'h010, 12'h002);
		check("busy seen", {7'h00, busy_seen}, 8'h01);
		check("ready after", {7'h00, rdy_busy_in}, 8'h01);
		run_op(FPC_OP_READ, 15'h4002, 12'h010, 12'h002);
		check("read count", 8'(rx.size()), 8'h03);
		foreach (rx[i]) begin
			check("program byte", rx[i], 8'hA5 + 8'h11 * 8'(i));
		end
		run_op(FPC_OP_PROG, 15'h4002, 12'h83E, 12'h001);
		run_op(FPC_OP_READ, 15'h4002, 12'h83E, 12'h001);
		check("marker count", 8'(rx.size()), 8'h02);
		check("marker back", rx[0], 8'h64);
		check("marker back", rx[1], 8'h65);
		$display("program test done");
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		t_status();
		t_read();
		t_status();
		t_erase();
		t_prog();
		stop_test();
	end
endmodule
